/* rtl/ssdp_pkg.sv */
// Constants, register map and carrier types for the four-channel
// synchronous serial DCE port.
// Assumes a single system clock domain; all DTE and link pins arrive asynchronously.
package ssdp_pkg;

  localparam int NCH  = 4;
  localparam int NIN  = 9;
  localparam int REGW = 12;

  // Positions in the per-channel sampled input vector
  localparam int IN_TXD = 0;
  localparam int IN_RTS = 1;
  localparam int IN_DTR = 2;
  localparam int IN_ETC = 3;
  localparam int IN_RL  = 4;
  localparam int IN_LL  = 5;
  localparam int IN_LCK = 6;
  localparam int IN_LRX = 7;
  localparam int IN_LOS = 8;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_EVT  = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0c;

  // Field base bits; channel n sits at base + n
  localparam int F_TXSEL = 0;
  localparam int F_RXSEL = 4;
  localparam int F_SWLL  = 8;
  localparam int F_RTS   = 0;
  localparam int F_LOS   = 4;
  localparam int F_TST   = 8;

  localparam logic [REGW-1:0] CTRL_RST = 12'h000;
  localparam logic [REGW-1:0] MASK_RST = 12'h000;

  typedef struct packed {
    logic txd;
    logic rts;
    logic dtr_clk;
    logic etc_clk;
    logic rl;
    logic ll;
  } ssdp_dte_in_t;

  typedef struct packed {
    logic rxd;
    logic rclk;
    logic tclk;
    logic cts;
    logic dsr;
    logic dcd;
    logic tm;
  } ssdp_dte_out_t;

  typedef struct packed {
    logic clk;
    logic rxd;
    logic los;
  } ssdp_link_in_t;

  typedef struct packed {
    logic txd;
    logic stb;
  } ssdp_link_out_t;

  typedef struct packed {
    logic [NIN-1:0] s1;
    logic [NIN-1:0] s2;
    logic [NIN-1:0] s3;
    logic           rxd;
    logic           rclk;
    logic           tclk;
    logic           cts;
    logic           dsr;
    logic           dcd;
    logic           tm;
    logic           ltxd;
    logic           lstb;
  } ssdp_ch_t;

  typedef struct packed {
    ssdp_ch_t [NCH-1:0] ch;
    logic [REGW-1:0]    ctrl;
    logic [REGW-1:0]    mask;
    logic [REGW-1:0]    evt;
    logic [31:0]        rdata;
    logic               irq;
  } ssdp_st_t;

endpackage : ssdp_pkg

/* rtl/ssdp_port.sv */
// Four independent synchronous serial DCE channels with a small
// register file and one level interrupt.
// Assumes all DTE and link pins are asynchronous to sys_clk and their
// clocks are at most a quarter of the sys_clk rate.
// Behaviour
// - Four channels, sharing only the register file and the interrupt
// - Receive data carries the recovered link stream, or the terminal's transmit data during local loop
// - Clear-to-send on; ready off during loops
// - Carrier detect drops only on carrier loss
// - Terminal-ready pin is a receive clock input
// - External transmit clock input accepted
// - Transmit bit clock driven to terminal
// - Receive bit clock driven with receive data
// - Remote loop while its command is held
// - Local loop while its command is held
// - Test indicator on during any test
// - Terminal takes timing from our clocks
`timescale 1ns/1ps
module ssdp_port (
  input  wire logic                   sys_clk,   // System clock, 10 MHz
  input  wire logic                   rst_n,     // Async reset
  input  wire logic [7:0]             reg_addr,  // Register byte address
  input  wire logic [31:0]            reg_wdata, // Write data
  input  wire logic                   reg_wr,    // Write strobe
  input  wire logic                   reg_rd,    // Read strobe
  output logic [31:0]                 reg_rdata, // Read data, next cycle
  output logic                        irq,       // Level interrupt
  input  ssdp_pkg::ssdp_dte_in_t  [3:0] dte_i,   // Terminal pins in
  output ssdp_pkg::ssdp_dte_out_t [3:0] dte_o,   // Terminal pins out
  input  ssdp_pkg::ssdp_link_in_t [3:0] link_i,  // Recovered link in
  output ssdp_pkg::ssdp_link_out_t [3:0] link_o  // Link payload out
);

  ssdp_pkg::ssdp_st_t q;
  ssdp_pkg::ssdp_st_t n;

  logic [3:0] lpl_w;
  logic [3:0] tst_w;
  logic [3:0] txc_w;
  logic [3:0] txp_w;
  logic [3:0] txr_w;
  logic [3:0] rxc_w;
  logic [3:0] rxp_w;
  logic [3:0] rxf_w;

  function automatic logic [ssdp_pkg::NIN-1:0] pack_in(
    input ssdp_pkg::ssdp_dte_in_t  d,
    input ssdp_pkg::ssdp_link_in_t l
  );
    logic [ssdp_pkg::NIN-1:0] v;
    v = '0;
    v[ssdp_pkg::IN_TXD] = d.txd;
    v[ssdp_pkg::IN_RTS] = d.rts;
    v[ssdp_pkg::IN_DTR] = d.dtr_clk;
    v[ssdp_pkg::IN_ETC] = d.etc_clk;
    v[ssdp_pkg::IN_RL]  = d.rl;
    v[ssdp_pkg::IN_LL]  = d.ll;
    v[ssdp_pkg::IN_LCK] = l.clk;
    v[ssdp_pkg::IN_LRX] = l.rxd;
    v[ssdp_pkg::IN_LOS] = l.los;
    return v;
  endfunction : pack_in

  function automatic logic rose(
    input logic [ssdp_pkg::NIN-1:0] now,
    input logic [ssdp_pkg::NIN-1:0] last,
    input int                        idx
  );
    return now[idx] & ~last[idx];
  endfunction : rose

  function automatic logic hit(
    input logic [7:0] addr,
    input logic [7:0] off
  );
    return addr == off;
  endfunction : hit

  // Per-channel clock selection and edge finding
  for (genvar g = 0; g < ssdp_pkg::NCH; g++) begin : g_ch
    assign lpl_w[g] = q.ch[g].s2[ssdp_pkg::IN_LL]
                    | q.ctrl[ssdp_pkg::F_SWLL+g];
    assign tst_w[g] = q.ch[g].s2[ssdp_pkg::IN_RL] | lpl_w[g];
    // Transmit sampling clock: recovered or terminal-supplied
    assign txc_w[g] = q.ctrl[ssdp_pkg::F_TXSEL+g]
                    ? q.ch[g].s2[ssdp_pkg::IN_ETC]
                    : q.ch[g].s2[ssdp_pkg::IN_LCK];
    assign txp_w[g] = q.ctrl[ssdp_pkg::F_TXSEL+g]
                    ? q.ch[g].s3[ssdp_pkg::IN_ETC]
                    : q.ch[g].s3[ssdp_pkg::IN_LCK];
    assign txr_w[g] = txc_w[g] & ~txp_w[g];
    // Receive clock: recovered or the terminal-ready circuit
    assign rxc_w[g] = q.ctrl[ssdp_pkg::F_RXSEL+g]
                    ? q.ch[g].s2[ssdp_pkg::IN_DTR]
                    : q.ch[g].s2[ssdp_pkg::IN_LCK];
    assign rxp_w[g] = q.ctrl[ssdp_pkg::F_RXSEL+g]
                    ? q.ch[g].s3[ssdp_pkg::IN_DTR]
                    : q.ch[g].s3[ssdp_pkg::IN_LCK];
    assign rxf_w[g] = ~rxc_w[g] & rxp_w[g];

    assign dte_o[g].rxd  = q.ch[g].rxd;
    assign dte_o[g].rclk = q.ch[g].rclk;
    assign dte_o[g].tclk = q.ch[g].tclk;
    assign dte_o[g].cts  = q.ch[g].cts;
    assign dte_o[g].dsr  = q.ch[g].dsr;
    assign dte_o[g].dcd  = q.ch[g].dcd;
    assign dte_o[g].tm   = q.ch[g].tm;
    assign link_o[g].txd = q.ch[g].ltxd;
    assign link_o[g].stb = q.ch[g].lstb;
  end

  assign reg_rdata = q.rdata;
  assign irq       = q.irq;

  always_comb begin
    logic [ssdp_pkg::REGW-1:0] sts;
    logic [ssdp_pkg::REGW-1:0] nev;
    sts = '0;
    nev = '0;
    n = q;
    n.rdata = '0;
    for (int i = 0; i < ssdp_pkg::NCH; i++) begin
      // Two-stage synchroniser, third stage for edges
      n.ch[i].s1 = pack_in(dte_i[i], link_i[i]);
      n.ch[i].s2 = q.ch[i].s1;
      n.ch[i].s3 = q.ch[i].s2;
      n.ch[i].cts  = 1'b1;
      n.ch[i].dsr  = ~tst_w[i];
      n.ch[i].dcd  = ~q.ch[i].s2[ssdp_pkg::IN_LOS];
      n.ch[i].tm   = tst_w[i];
      // Terminal times its data from this clock
      n.ch[i].tclk = q.ch[i].s2[ssdp_pkg::IN_LCK];
      n.ch[i].rclk = rxc_w[i];
      // Receive data changes on the falling receive clock edge
      if (rxf_w[i]) begin
        if (lpl_w[i]) begin
          n.ch[i].rxd = q.ch[i].s2[ssdp_pkg::IN_TXD];
        end else begin
          n.ch[i].rxd = q.ch[i].s2[ssdp_pkg::IN_LRX];
        end
      end
      // Transmit data is taken on the rising transmit clock edge
      n.ch[i].lstb = txr_w[i];
      if (txr_w[i]) begin
        if (q.ch[i].s2[ssdp_pkg::IN_RL]) begin
          n.ch[i].ltxd = q.ch[i].s2[ssdp_pkg::IN_LRX];
        end else begin
          n.ch[i].ltxd = q.ch[i].s2[ssdp_pkg::IN_TXD];
        end
      end
      sts[ssdp_pkg::F_RTS+i] = q.ch[i].s2[ssdp_pkg::IN_RTS];
      sts[ssdp_pkg::F_LOS+i] = q.ch[i].s2[ssdp_pkg::IN_LOS];
      sts[ssdp_pkg::F_TST+i] = tst_w[i];
      nev[ssdp_pkg::F_LOS+i] = rose(q.ch[i].s2, q.ch[i].s3, ssdp_pkg::IN_LOS);
      nev[ssdp_pkg::F_TST+i] = tst_w[i] & ~q.ch[i].tm;
      nev[ssdp_pkg::F_RTS+i] = rose(q.ch[i].s2, q.ch[i].s3, ssdp_pkg::IN_RTS);
    end

    if (reg_wr && hit(reg_addr, ssdp_pkg::OFF_CTRL)) begin
      n.ctrl = reg_wdata[ssdp_pkg::REGW-1:0];
    end
    if (reg_wr && hit(reg_addr, ssdp_pkg::OFF_MASK)) begin
      n.mask = reg_wdata[ssdp_pkg::REGW-1:0];
    end

    // New events win over the clear of a read in the same cycle
    if (reg_rd && hit(reg_addr, ssdp_pkg::OFF_EVT)) begin
      n.evt = nev;
    end else begin
      n.evt = q.evt | nev;
    end

    if (reg_rd) begin
      case (reg_addr)
        ssdp_pkg::OFF_CTRL: n.rdata = {20'h0, q.ctrl};
        ssdp_pkg::OFF_STAT: n.rdata = {20'h0, sts};
        ssdp_pkg::OFF_EVT:  n.rdata = {20'h0, q.evt};
        ssdp_pkg::OFF_MASK: n.rdata = {20'h0, q.mask};
        default:            n.rdata = 32'h0;
      endcase
    end

    n.irq = |(n.evt & n.mask);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      q      <= '0;
      q.ctrl <= ssdp_pkg::CTRL_RST;
      q.mask <= ssdp_pkg::MASK_RST;
    end else begin
      q <= n;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);

  a_cts_held: assert property ($past(rst_n) |-> q.ch[0].cts)
    else $error("clear-to-send not held on");

  a_dsr_test: assert property ($past(rst_n) |-> q.ch[0].dsr != q.ch[0].tm)
    else $error("data-set-ready not opposite of test");

  a_dcd_loss: assert property (
    $rose(q.ch[0].s2[ssdp_pkg::IN_LOS]) |=> !q.ch[0].dcd ##1 !q.ch[0].dcd)
    else $error("carrier detect not dropped on loss");

  a_dcd_ok: assert property (
    $fell(q.ch[0].s2[ssdp_pkg::IN_LOS]) |=> q.ch[0].dcd)
    else $error("carrier detect not restored");

  a_rl_test: assert property (
    q.ch[0].s2[ssdp_pkg::IN_RL] |=> q.ch[0].tm && !q.ch[0].dsr)
    else $error("remote loop did not show test");

  a_test_end: assert property (
    !tst_w[0] |=> !q.ch[0].tm)
    else $error("test indicator stuck on");

  a_ll_rxd: assert property (
    lpl_w[0] && rxf_w[0] |=> q.ch[0].rxd == $past(q.ch[0].s2[ssdp_pkg::IN_TXD]))
    else $error("local loop data not returned");

  a_rx_data: assert property (
    !lpl_w[0] && rxf_w[0] |=> q.ch[0].rxd == $past(q.ch[0].s2[ssdp_pkg::IN_LRX]))
    else $error("receive data not from link");

  a_rl_return: assert property (
    q.ch[0].s2[ssdp_pkg::IN_RL] && txr_w[0]
    |=> q.ch[0].lstb && q.ch[0].ltxd == $past(q.ch[0].s2[ssdp_pkg::IN_LRX]))
    else $error("remote loop data not returned");

  a_tx_sample: assert property (
    !q.ch[0].s2[ssdp_pkg::IN_RL] && txr_w[0]
    |=> q.ch[0].lstb && q.ch[0].ltxd == $past(q.ch[0].s2[ssdp_pkg::IN_TXD]))
    else $error("transmit data not sampled");

  a_stb_pulse: assert property (q.ch[0].lstb |=> !q.ch[0].lstb)
    else $error("transmit strobe longer than one cycle");

  a_rclk_fall: assert property (rxf_w[0] |=> !q.ch[0].rclk)
    else $error("receive clock out of step");

  a_irq_gate: assert property ((q.evt & q.mask) != 12'h000 |-> irq)
    else $error("unmasked event without interrupt");

  a_rd_ctrl: assert property (
    reg_rd && reg_addr == ssdp_pkg::OFF_CTRL
    |=> reg_rdata == {20'h0, $past(q.ctrl)} ##1 reg_rdata == 32'h0 || $past(reg_rd))
    else $error("control readback wrong");

  a_tclk_follow: assert property (
    $past(rst_n) |-> q.ch[0].tclk == $past(q.ch[0].s2[ssdp_pkg::IN_LCK]))
    else $error("transmit clock not following link clock");

  a_evt_los: assert property (
    $rose(q.ch[0].s2[ssdp_pkg::IN_LOS]) |=> q.evt[ssdp_pkg::F_LOS])
    else $error("carrier loss event not latched");

  a_evt_rts: assert property (
    $rose(q.ch[0].s2[ssdp_pkg::IN_RTS]) |=> q.evt[ssdp_pkg::F_RTS])
    else $error("request-to-send event not latched");

  a_evt_tst: assert property (
    $rose(tst_w[0]) |=> q.evt[ssdp_pkg::F_TST])
    else $error("test start event not latched");

  a_irq_quiet: assert property ((q.evt & q.mask) == 12'h000 |-> !irq)
    else $error("interrupt without unmasked event");

  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not cleared after read");

  a_stat_test: assert property (
    reg_rd && reg_addr == ssdp_pkg::OFF_STAT
    |=> reg_rdata[ssdp_pkg::F_TST] == $past(tst_w[0]))
    else $error("status test bit wrong");

  // Most channel 0 guards on the other channels, plus data hold checks; each sees only its own pins
  for (genvar k = 1; k < ssdp_pkg::NCH; k++) begin : g_chk
    a_cts_chan: assert property (
      $past(rst_n) |-> q.ch[k].cts)
      else $error("clear-to-send not held on");

    a_dsr_chan: assert property (
      $past(rst_n) |-> q.ch[k].dsr != q.ch[k].tm)
      else $error("data-set-ready not opposite of test");

    a_dcd_chan: assert property (
      $rose(q.ch[k].s2[ssdp_pkg::IN_LOS]) |=> !q.ch[k].dcd)
      else $error("carrier detect not dropped on loss");

    a_rl_chan: assert property (
      q.ch[k].s2[ssdp_pkg::IN_RL] |=> q.ch[k].tm && !q.ch[k].dsr)
      else $error("remote loop did not show test");

    a_tm_chan: assert property (
      !tst_w[k] |=> !q.ch[k].tm)
      else $error("test indicator stuck on");

    a_ll_chan: assert property (
      lpl_w[k] && rxf_w[k] |=> q.ch[k].rxd == $past(q.ch[k].s2[ssdp_pkg::IN_TXD]))
      else $error("local loop data not returned");

    a_rx_chan: assert property (
      !lpl_w[k] && rxf_w[k] |=> q.ch[k].rxd == $past(q.ch[k].s2[ssdp_pkg::IN_LRX]))
      else $error("receive data not from link");

    a_tx_chan: assert property (
      !q.ch[k].s2[ssdp_pkg::IN_RL] && txr_w[k]
      |=> q.ch[k].lstb && q.ch[k].ltxd == $past(q.ch[k].s2[ssdp_pkg::IN_TXD]))
      else $error("transmit data not sampled");

    a_rlret_chan: assert property (
      q.ch[k].s2[ssdp_pkg::IN_RL] && txr_w[k]
      |=> q.ch[k].lstb && q.ch[k].ltxd == $past(q.ch[k].s2[ssdp_pkg::IN_LRX]))
      else $error("remote loop data not returned");

    a_rclk_chan: assert property (
      rxf_w[k] |=> !q.ch[k].rclk)
      else $error("receive clock out of step");

    a_tclk_chan: assert property (
      $past(rst_n) |-> q.ch[k].tclk == $past(q.ch[k].s2[ssdp_pkg::IN_LCK]))
      else $error("transmit clock not following link clock");

    a_txd_hold: assert property (
      !txr_w[k] |=> $stable(q.ch[k].ltxd))
      else $error("link data moved between clock edges");

    a_rxd_hold: assert property (
      !rxf_w[k] |=> $stable(q.ch[k].rxd))
      else $error("receive data moved between clock edges");
  end

  c_remote: cover property (q.ch[0].s2[ssdp_pkg::IN_RL] ##1 q.ch[0].tm);
  c_local: cover property (lpl_w[0] && rxf_w[0]);
  c_ext_tx: cover property (txr_w[0] && q.ctrl[ssdp_pkg::F_TXSEL]);
  c_irq: cover property ($rose(irq));

endmodule : ssdp_port

/* verification/ssdp_dte_model.sv */
// Terminal model for one channel, running in recovery timing.
// Assumes the port's transmit clock and a bench-supplied bit pattern.
`timescale 1ns/1ps
module ssdp_dte_model (
  input  wire logic                    pat, // Next bit to send
  input  wire logic                    rts, // Wish to send
  input  wire logic [1:0]              lp,  // Remote, local loop
  input  wire ssdp_pkg::ssdp_dte_out_t o,   // Port outputs
  output ssdp_pkg::ssdp_dte_in_t       i    // Port inputs
);
  logic txd_q = 1'b0;
  logic dtr_q = 1'b0;
  always @(negedge o.tclk) txd_q <= pat;
  initial forever #500 dtr_q = ~dtr_q;
  always_comb begin
    i.txd     = txd_q;
    i.rts     = rts;
    i.dtr_clk = dtr_q;
    i.etc_clk = o.tclk;
    i.rl      = lp[1];
    i.ll      = lp[0];
  end
endmodule : ssdp_dte_model

/* verification/ssdp_port_tb.sv */
// Self-checking bench for the four-channel serial port.
// Assumes a link clock of 800 ns unrelated to sys_clk.
`timescale 1ns/1ps
module ssdp_port_tb;
  logic                          sys_clk = 1'b0;
  logic                          rst_n = 1'b0;
  logic [7:0]                    reg_addr = 8'h00;
  logic [31:0]                   reg_wdata = 32'h0;
  logic                          reg_wr = 1'b0;
  logic                          reg_rd = 1'b0;
  logic [31:0]                   reg_rdata;
  logic                          irq;
  ssdp_pkg::ssdp_dte_in_t  [3:0] dte_i;
  ssdp_pkg::ssdp_dte_out_t [3:0] dte_o;
  ssdp_pkg::ssdp_link_in_t [3:0] link_i;
  ssdp_pkg::ssdp_link_out_t [3:0] link_o;
  logic [3:0]  pat = 4'h0, rts = 4'h0, rl = 4'h0, ll = 4'h0;
  logic [3:0]  lrx = 4'h0, los = 4'h0, rk = 4'h0;
  logic        lclk = 1'b0, chk = 1'b0, rd_q = 1'b0;
  logic [15:0] lf = 16'h000a;
  logic [3:0]  e;
  logic [31:0] rdq[$];
  logic        txq[4][$];
  logic        rxq[4][$];
  int          n_errors = 0, compares = 0, f;

  ssdp_port DUT (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
                 .reg_rdata, .irq, .dte_i, .dte_o, .link_i, .link_o);

  function automatic logic [15:0] nx(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx

  initial forever #50 sys_clk = ~sys_clk;
  initial begin
    #137;
    forever #400 lclk = ~lclk;
  end
  always @(negedge lclk) lf <= nx(lf);

  for (genvar c = 0; c < 4; c++) begin : g_ch
    ssdp_dte_model u_dte (.pat(pat[c]), .rts(rts[c]), .lp({rl[c], ll[c]}),
                          .o(dte_o[c]), .i(dte_i[c]));
    assign link_i[c] = {lclk, lrx[c], los[c]};
    always @(negedge lclk) lrx[c] <= lf[c];
    always @(posedge lclk) if (chk) begin
      rxq[c].push_back(lrx[c]);
      if (rl[c]) txq[c].push_back(lrx[c]);
    end
    always @(negedge dte_o[c].tclk) begin
      if (chk && !rl[c]) txq[c].push_back(pat[c]);
      pat[c] <= lf[c + 4];
    end
    always @(posedge sys_clk) begin
      rk[c] <= dte_o[c].rclk;
      if (link_o[c].stb === 1'b1 && txq[c].size() > 0)
        check(link_o[c].txd, txq[c].pop_front());
      if (dte_o[c].rclk === 1'b1 && rk[c] === 1'b0 && rxq[c].size() > 0)
        check(dte_o[c].rxd, rxq[c].pop_front());
    end
  end

  always @(posedge sys_clk) begin
    rd_q <= reg_rd;
    if (rd_q) check(reg_rdata, rdq.pop_front());
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rdq.push_back(x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask : rd

  task automatic stream(input logic [31:0] ctl, input logic [3:0] rlm);
    int k = 0;
    chk <= 1'b0;
    rl <= rlm;
    wr(ssdp_pkg::OFF_CTRL, ctl);
    for (int c = 0; c < 4; c++) begin
      txq[c].delete();
      rxq[c].delete();
    end
    repeat (20) @(posedge sys_clk);
    // Start right after a transmit clock rise
    while (dte_o[0].tclk !== 1'b0 && k < 30) begin
      @(posedge sys_clk);
      k++;
    end
    while (dte_o[0].tclk !== 1'b1 && k < 30) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= 30) begin
      n_errors++;
      end_of_test();
    end
    chk <= 1'b1;
    repeat (400) @(posedge sys_clk);
    chk <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      check(txq[c].size() < 3, 32'h1);
      check(rxq[c].size() < 3, 32'h1);
    end
    rl <= 4'h0;
    $display("stream done, ctrl %h", ctl);
  endtask : stream

  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(ssdp_pkg::OFF_CTRL, 32'h0);
    rd(ssdp_pkg::OFF_MASK, 32'h0);
    rd(ssdp_pkg::OFF_EVT, 32'h0);
    check({dte_o[0].cts, dte_o[0].dsr, dte_o[0].dcd, dte_o[0].tm}, 4'he);
    rts[0] <= 1'b1;
    repeat (8) @(posedge sys_clk);
    check(irq, 1'b0);
    rd(ssdp_pkg::OFF_STAT, 32'h1);
    rd(ssdp_pkg::OFF_EVT, 32'h1);
    rts[0] <= 1'b0;
    wr(8'h10, 32'hfff);
    rd(8'h10, 32'h0);
    wr(ssdp_pkg::OFF_STAT, 32'hfff);
    rd(ssdp_pkg::OFF_STAT, 32'h0);
    wr(ssdp_pkg::OFF_MASK, 32'hfff);
    rd(ssdp_pkg::OFF_MASK, 32'hfff);
    $display("register test done");
    for (int m = 0; m < 5; m++) begin
      for (int c = 0; c < 4; c++) begin
        f = (m < 3) ? 8 + c : (m == 3) ? 4 + c : c;
        e = (m < 3) ? 4'hb : (m == 3) ? 4'hc : 4'he;
        if (m == 0) rl[c] <= 1'b1;
        if (m == 1) ll[c] <= 1'b1;
        if (m == 2) wr(ssdp_pkg::OFF_CTRL, 32'h1 << f);
        if (m == 3) los[c] <= 1'b1;
        if (m == 4) rts[c] <= 1'b1;
        repeat (8) @(posedge sys_clk);
        check(irq, 1'b1);
        check({dte_o[c].cts, dte_o[c].dsr, dte_o[c].dcd, dte_o[c].tm}, e);
        check(dte_o[c ^ 1].tm, 1'b0);
        rd(ssdp_pkg::OFF_STAT, 32'h1 << f);
        rd(ssdp_pkg::OFF_EVT, 32'h1 << f);
        rd(ssdp_pkg::OFF_EVT, 32'h0);
        check(irq, 1'b0);
        rl <= 4'h0;
        ll <= 4'h0;
        los <= 4'h0;
        rts <= 4'h0;
        wr(ssdp_pkg::OFF_CTRL, 32'h0);
        repeat (8) @(posedge sys_clk);
        check(dte_o[c].dsr & ~dte_o[c].tm, 1'b1);
      end
      $display("status mode %0d done", m);
    end
    stream(32'h0, 4'h0);
    stream(32'h00f, 4'h0);
    stream(32'h0, 4'h5);
    end_of_test();
  end
endmodule : ssdp_port_tb
